// ### hdl/tmr8_pkg.sv
/*
  constants, field layout and carrier types of the 8-bit timer with two
  compare channels. assumes a register port with 3-bit byte addresses.
*/
package tmr8_pkg;
  // ********************
  // register offsets
  // ********************
  localparam logic [2:0] ADDR_CTRL_A  = 3'h0;
  localparam logic [2:0] ADDR_CTRL_B  = 3'h1;
  localparam logic [2:0] ADDR_CTRL_C  = 3'h2;
  localparam logic [2:0] ADDR_COUNT   = 3'h3;
  localparam logic [2:0] ADDR_MATCH_A = 3'h4;
  localparam logic [2:0] ADDR_MATCH_B = 3'h5;
  localparam logic [2:0] ADDR_FLAG    = 3'h6;
  localparam logic [2:0] ADDR_MASK    = 3'h7;
  // ********************
  // fields and values
  // ********************
  localparam int         POS_WK_HI    = 3;
  localparam int         POS_FORCE_A  = 7;
  localparam int         POS_ACT_A    = 6;
  localparam int         POS_ACT_B    = 4;
  localparam int         POS_OVF      = 0;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [7:0] CNT_MAX      = 8'hff;
  localparam logic [7:0] CNT_BOTTOM   = 8'h00;
  localparam logic [2:0] WK_NORMAL    = 3'h0;
  localparam logic [2:0] WK_CTC       = 3'h2;
  localparam logic [2:0] SRC_OFF      = 3'h0;
  localparam logic [2:0] SRC_DIV8     = 3'h2;
  localparam logic [2:0] SRC_DIV64    = 3'h3;
  localparam logic [2:0] SRC_DIV256   = 3'h4;
  localparam logic [2:0] SRC_DIV1024  = 3'h5;
  localparam logic [2:0] SRC_EXT_FALL = 3'h6;
  localparam logic [2:0] SRC_EXT_RISE = 3'h7;
  localparam logic [1:0] ACT_NONE     = 2'h0;
  localparam logic [1:0] ACT_TOGGLE   = 2'h1;
  localparam logic [1:0] ACT_CLEAR    = 2'h2;
  localparam logic [1:0] ACT_SET      = 2'h3;
  // ********************
  // types
  // ********************
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmr8_bus_type;
  typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DOWN = 2'b10} tmr8_dir_type;
endpackage

// ### hdl/tmr8_timer.sv
/*
  8-bit timer/counter with two compare channels, tick selection, flags,
  masks and compare double buffering. assumes a synchronous register
  master on clock and an ext_count_pin from outside the clock domain.
*/
// What this block does
// - counter and compare values are 8 bits
// - one flag register, one mask register
// - tick from clock, prescaler or pin; zero stops
// - three-bit tick select in control B
// - each tick clears, increments or decrements
// - counter readable and writable at any time
// - counter write beats clear or count
// - waveform kind split over controls A, B
// - overflow flag set per waveform kind
// - comparators match whenever values are equal
// - match flag set on next tick
// - match request gated by mask bit
// - flag clears on service or write one
// - outputs use match, kind, action, top, bottom
// - pwm writes buffered, loaded at top
// - normal and clear_on_match write directly
// - force strobe acts outside pwm, no flag, no reload
// - counter write blocks next tick match
// - output state kept across kind change
// - action select changes take effect immediately
// - top and bottom indications
// - max is 0xff, bottom is 0x00
// - top is max or channel a value
// - normal mode counts up, overflow at wrap
`timescale 1ns/1ps
module tmr8_timer
  import tmr8_pkg::*;
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         arst_n,
  // register port
  input  wire tmr8_bus_type bus_req,
  output logic [7:0]        rd_data_r,
  // interrupt requests and service acknowledge: overflow, match a, match b
  output logic [2:0]        irq_req_r,
  input  wire logic [2:0]   irq_ack,
  // external count pin
  input  wire logic         ext_count_pin,
  // compare output states
  output logic              wave_out_a,
  output logic              wave_out_b
);
  // ********************
  // registers
  // ********************
  logic [7:0]   control_reg_a;
  logic [7:0]   control_reg_b;
  logic [7:0]   count_value;
  logic [7:0]   timer_flag_reg;
  logic [7:0]   timer_mask_reg;
  logic [7:0]   buf_r [2];
  logic [7:0]   act_r [2];
  logic [1:0]   wave_r;
  logic         block_r;
  tmr8_dir_type dir_r;
  logic [9:0]   pre_r;
  logic [2:0]   pin_r;
  // ********************
  // decode
  // ********************
  logic [2:0] waveform_kind;
  logic [2:0] tick_source_select;
  logic       pwm;
  logic       phase;
  logic       fast;
  logic [7:0] top_val;
  logic       at_top;
  logic       at_bot;
  logic       timer_tick;
  logic       cnt_wr;
  logic       force_wr;
  logic [7:0] cnt_nxt;
  logic [1:0] match;
  logic [1:0] output_action_select [2];

  assign waveform_kind      = {control_reg_b[POS_WK_HI], control_reg_a[1:0]};
  assign tick_source_select = control_reg_b[2:0];
  assign pwm   = waveform_kind[0];
  assign phase = pwm & ~waveform_kind[1];
  assign fast  = pwm & waveform_kind[1];
  assign top_val = (waveform_kind == WK_CTC || waveform_kind[2]) ? act_r[0] : CNT_MAX;
  assign at_top  = (count_value == top_val);
  assign at_bot  = (count_value == CNT_BOTTOM);
  assign cnt_wr   = bus_req.wr && bus_req.addr == ADDR_COUNT;
  assign force_wr = bus_req.wr && bus_req.addr == ADDR_CTRL_C && !pwm;
  assign output_action_select[0] = control_reg_a[POS_ACT_A +: 2];
  assign output_action_select[1] = control_reg_a[POS_ACT_B +: 2];

  // ********************
  // tick source
  // ********************
  // pin_r[0] feeds pin_r[1] only; the edge is seen between [1] and [2]
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_r <= 3'h0;
    end else begin
      pin_r <= {pin_r[1:0], ext_count_pin};
    end
  end

  // free-running divider; phase is shared, so a source change may shorten a tick
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pre_r <= 10'h000;
    end else begin
      pre_r <= pre_r + 10'h001;
    end
  end

  always_comb begin
    unique case (tick_source_select)
      SRC_OFF:      timer_tick = 1'b0;
      SRC_DIV8:     timer_tick = &pre_r[2:0];
      SRC_DIV64:    timer_tick = &pre_r[5:0];
      SRC_DIV256:   timer_tick = &pre_r[7:0];
      SRC_DIV1024:  timer_tick = &pre_r;
      SRC_EXT_FALL: timer_tick = pin_r[2] & ~pin_r[1];
      SRC_EXT_RISE: timer_tick = ~pin_r[2] & pin_r[1];
      default:      timer_tick = 1'b1;
    endcase
  end

  // ********************
  // counter unit
  // ********************
  always_comb begin
    cnt_nxt = count_value + 8'h01;
    if (phase) begin
      // turn at top and at bottom; going down past bottom would wrap to max
      if ((dir_r == DIR_UP) ? at_top : !at_bot) begin
        cnt_nxt = count_value - 8'h01;
      end
    end else if ((fast || waveform_kind == WK_CTC) && at_top) begin
      cnt_nxt = CNT_BOTTOM;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_value <= RESET_BYTE;
      dir_r       <= DIR_UP;
    end else begin
      if (cnt_wr) begin
        count_value <= bus_req.wdata;
      end else if (timer_tick) begin
        count_value <= cnt_nxt;
      end
      if (!phase) begin
        dir_r <= DIR_UP;
      end else if (timer_tick && at_top) begin
        dir_r <= DIR_DOWN;
      end else if (timer_tick && at_bot) begin
        dir_r <= DIR_UP;
      end
    end
  end

  // blocking lasts until the next tick, however long the timer stands still
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      block_r <= 1'b0;
    end else if (cnt_wr) begin
      block_r <= 1'b1;
    end else if (timer_tick) begin
      block_r <= 1'b0;
    end
  end

  // ********************
  // control registers
  // ********************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      control_reg_a  <= RESET_BYTE;
      control_reg_b  <= RESET_BYTE;
      timer_mask_reg <= RESET_BYTE;
    end else if (bus_req.wr) begin
      if (bus_req.addr == ADDR_CTRL_A) control_reg_a <= bus_req.wdata;
      if (bus_req.addr == ADDR_CTRL_B) control_reg_b <= bus_req.wdata;
      if (bus_req.addr == ADDR_MASK) timer_mask_reg <= bus_req.wdata;
    end
  end

  // ********************
  // compare channels
  // ********************
  function automatic logic apply_act(input logic [1:0] act, input logic cur);
    unique case (act)
      ACT_TOGGLE: apply_act = ~cur;
      ACT_CLEAR:  apply_act = 1'b0;
      ACT_SET:    apply_act = 1'b1;
      default:    apply_act = cur;
    endcase
  endfunction

  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic wr_val;
    logic hit;
    logic up_edge;
    assign wr_val  = bus_req.wr && bus_req.addr == (ADDR_MATCH_A + 3'(c));
    assign match[c] = (count_value == act_r[c]);
    assign hit     = timer_tick && match[c] && !block_r;
    assign up_edge = (dir_r == DIR_UP);

    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        buf_r[c] <= RESET_BYTE;
        act_r[c] <= RESET_BYTE;
      end else begin
        if (wr_val) begin
          buf_r[c] <= bus_req.wdata;
        end
        if (wr_val && !pwm) begin
          act_r[c] <= bus_req.wdata;
        end else if (pwm && timer_tick && at_top) begin
          act_r[c] <= buf_r[c];
        end
      end
    end

    // kind changes leave the state alone; only events move it
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        wave_r[c] <= 1'b0;
      end else if (force_wr && bus_req.wdata[POS_FORCE_A - c]) begin
        wave_r[c] <= apply_act(output_action_select[c], wave_r[c]);
      end else if (!pwm && hit) begin
        wave_r[c] <= apply_act(output_action_select[c], wave_r[c]);
      end else if (pwm && hit && output_action_select[c] == ACT_TOGGLE) begin
        if (c == 0 && waveform_kind[2]) wave_r[c] <= ~wave_r[c];
      end else if (pwm && hit && output_action_select[c][1]) begin
        wave_r[c] <= output_action_select[c][0] ^ (phase && !up_edge);
      end else if (fast && timer_tick && at_top && output_action_select[c][1]) begin
        wave_r[c] <= ~output_action_select[c][0];
      end
    end

    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        timer_flag_reg[c + 1] <= 1'b0;
      end else if (hit) begin
        timer_flag_reg[c + 1] <= 1'b1;
      end else if (irq_ack[c + 1] ||
                   (bus_req.wr && bus_req.addr == ADDR_FLAG && bus_req.wdata[c + 1])) begin
        timer_flag_reg[c + 1] <= 1'b0;
      end
    end
  end

  // ********************
  // overflow flag
  // ********************
  logic ovf_set;
  assign ovf_set = timer_tick && (phase ? (at_bot && dir_r == DIR_DOWN) :
                   fast ? at_top : (count_value == CNT_MAX));

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      timer_flag_reg[POS_OVF] <= 1'b0;
    end else if (ovf_set && !cnt_wr) begin
      timer_flag_reg[POS_OVF] <= 1'b1;
    end else if (irq_ack[POS_OVF] ||
                 (bus_req.wr && bus_req.addr == ADDR_FLAG && bus_req.wdata[POS_OVF])) begin
      timer_flag_reg[POS_OVF] <= 1'b0;
    end
  end
  assign timer_flag_reg[7:3] = 5'h00;

  // ********************
  // requests and readback
  // ********************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_req_r <= 3'h0;
    end else begin
      irq_req_r <= timer_flag_reg[2:0] & timer_mask_reg[2:0];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= RESET_BYTE;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_CTRL_A:  rd_data_r <= control_reg_a;
        ADDR_CTRL_B:  rd_data_r <= control_reg_b;
        ADDR_COUNT:   rd_data_r <= count_value;
        ADDR_MATCH_A: rd_data_r <= buf_r[0];
        ADDR_MATCH_B: rd_data_r <= buf_r[1];
        ADDR_FLAG:    rd_data_r <= timer_flag_reg;
        ADDR_MASK:    rd_data_r <= timer_mask_reg;
        default:      rd_data_r <= RESET_BYTE;
      endcase
    end else begin
      rd_data_r <= RESET_BYTE;
    end
  end

  assign wave_out_a = wave_r[0];
  assign wave_out_b = wave_r[1];

  // ********************
  // checks
  // ********************
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  count_write_a: assert property (cnt_wr |=> count_value == $past(bus_req.wdata))
    else $error("counter write lost");
  stopped_hold_a: assert property (tick_source_select == SRC_OFF && !cnt_wr
    |=> $stable(count_value))
    else $error("counter moved while stopped");
  match_block_a: assert property (block_r && timer_tick && !timer_flag_reg[1]
    |=> !timer_flag_reg[1])
    else $error("match not blocked after counter write");
  flag_set_a: assert property (timer_tick && !block_r && match[0] |=> timer_flag_reg[1])
    else $error("match flag not set");
  irq_gate_a: assert property (irq_req_r[1] |-> $past(timer_mask_reg[1]))
    else $error("request raised while masked");
  flag_clear_a: assert property (bus_req.wr && bus_req.addr == ADDR_FLAG &&
    bus_req.wdata[2] && !(timer_tick && match[1] && !block_r) |=> !timer_flag_reg[2])
    else $error("flag write one did not clear");
  normal_wrap_a: assert property (waveform_kind == WK_NORMAL && timer_tick &&
    count_value == CNT_MAX && !cnt_wr |=> at_bot && timer_flag_reg[POS_OVF])
    else $error("normal wrap wrong");
  buffer_hold_a: assert property (pwm && !(timer_tick && at_top) ##1 pwm
    |-> $stable(act_r[0]))
    else $error("active compare changed off top");
  force_flag_a: assert property (force_wr && !timer_tick && !timer_flag_reg[1]
    |=> !timer_flag_reg[1])
    else $error("force set a flag");
  ack_clear_a: assert property (irq_ack[1] && !(timer_tick && match[0] && !block_r)
    |=> !timer_flag_reg[1])
    else $error("acknowledge did not clear flag");
  irq_raise_a: assert property (timer_flag_reg[2] && timer_mask_reg[2] |=> irq_req_r[2])
    else $error("enabled flag raised no request");
  irq_drop_a: assert property (!timer_flag_reg[0] |=> !irq_req_r[0])
    else $error("overflow request without flag");

  // counting sequences
  count_step_a: assert property (waveform_kind == WK_NORMAL && timer_tick && !cnt_wr
    |=> count_value == $past(count_value) + 8'h01)
    else $error("normal count did not step up");
  clear_top_a: assert property (waveform_kind == WK_CTC && timer_tick && at_top
    && !cnt_wr |=> at_bot)
    else $error("clear_on_match did not clear at top");
  fast_wrap_a: assert property (fast && timer_tick && at_top && !cnt_wr |=> at_bot)
    else $error("fast pwm did not restart at bottom");
  phase_turn_a: assert property (phase && timer_tick && dir_r == DIR_DOWN && at_bot
    && !at_top && !cnt_wr |=> dir_r == DIR_UP && count_value == CNT_BOTTOM + 8'h01)
    else $error("phase count did not turn at bottom");

  // compare storage and outputs
  direct_write_a: assert property (bus_req.wr && bus_req.addr == ADDR_MATCH_B && !pwm
    |=> act_r[1] == $past(bus_req.wdata))
    else $error("compare write not direct");
  buffer_load_a: assert property (pwm && timer_tick && at_top
    |=> act_r[1] == $past(buf_r[1]))
    else $error("buffer not loaded at top");
  force_act_a: assert property (force_wr && bus_req.wdata[POS_FORCE_A - 1] &&
    output_action_select[1] == ACT_SET |=> wave_r[1])
    else $error("force strobe did not act");
  kind_keep_a: assert property (bus_req.wr && bus_req.addr == ADDR_CTRL_A
    && !timer_tick |=> $stable(wave_r))
    else $error("output state moved on kind change");
endmodule

// ### verif/tmr8_timer_test.sv
/*
  self-checking bench for tmr8_timer: register tasks, tick sources,
  flags, masks, force strobes and compare buffering.
  assumes tmr8_pkg and the tmr8_timer design are compiled first.
*/
`timescale 1ns/1ps
module tmr8_timer_test
  import tmr8_pkg::*;
;
  // ********************
  // signals
  // ********************
  logic         clock;
  logic         arst_n;
  tmr8_bus_type bus_req;
  logic [7:0]   rd_data_r;
  logic [2:0]   irq_req_r;
  logic [2:0]   irq_ack;
  logic         ext_count_pin;
  logic         wave_out_a;
  logic         wave_out_b;
  int           errors;
  int           n_checks;
  logic [7:0]   v;

  tmr8_timer u_dut (
    .clock         (clock),
    .arst_n        (arst_n),
    .bus_req       (bus_req),
    .rd_data_r     (rd_data_r),
    .irq_req_r     (irq_req_r),
    .irq_ack       (irq_ack),
    .ext_count_pin (ext_count_pin),
    .wave_out_a    (wave_out_a),
    .wave_out_b    (wave_out_b)
  );

  // ********************
  // tasks
  // ********************
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1;
    d = rd_data_r;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic pin_pulses(input int n);
    repeat (n) begin
      @(posedge clock) ext_count_pin <= 1'b1;
      wait_clk(6);
      ext_count_pin <= 1'b0;
      wait_clk(6);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ********************
  // clock, reset, watchdog
  // ********************
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    wait_clk(40000);
    errors++;
    close_out();
  end

  // ********************
  // tests
  // ********************
  initial begin
    arst_n = 1'b0;
    bus_req = '0;
    irq_ack = 3'h0;
    ext_count_pin = 1'b0;
    errors = 0;
    n_checks = 0;
    wait_clk(5);
    @(posedge clock) arst_n <= 1'b1;
    // reset state, ctrl_c write only
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), v);
      chk("reset reg", v, RESET_BYTE);
    end
    chk("reset outs", {3'h0, irq_req_r, wave_out_a, wave_out_b}, 8'h00);
    $display("test reset done");
    // storage and field layout
    wr(ADDR_CTRL_A, 8'hf3);
    wr(ADDR_CTRL_B, 8'h08);
    rd(ADDR_CTRL_A, v);
    chk("ctrl_a", v, 8'hf3);
    rd(ADDR_CTRL_B, v);
    chk("ctrl_b", v, 8'h08);
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_CTRL_B, 8'h00);
    wr(ADDR_MATCH_A, 8'ha5);
    wr(ADDR_MATCH_B, 8'h5a);
    wr(ADDR_COUNT, 8'h3c);
    wait_clk(20);
    rd(ADDR_MATCH_A, v);
    chk("match a", v, 8'ha5);
    rd(ADDR_MATCH_B, v);
    chk("match b", v, 8'h5a);
    rd(ADDR_COUNT, v);
    chk("count stopped", v, 8'h3c);
    $display("test registers done");
    // normal wrap sets overflow, masked request
    wr(ADDR_MATCH_A, 8'h00);
    wr(ADDR_MATCH_B, 8'h00);
    wr(ADDR_MASK, 8'h01);
    wr(ADDR_COUNT, CNT_MAX - 8'h02);
    wr(ADDR_CTRL_B, 8'h01);
    wait_clk(10);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_FLAG, v);
    chk("wrap flags", v, 8'h07);
    chk("ovf irq", {5'h0, irq_req_r}, 8'h01);
    wr(ADDR_FLAG, 8'h07);
    wait_clk(2);
    rd(ADDR_FLAG, v);
    chk("flags cleared", v, 8'h00);
    chk("irq cleared", {5'h0, irq_req_r}, 8'h00);
    $display("test overflow done");
    // match flag on next tick, serviced by acknowledge
    wr(ADDR_MATCH_A, 8'h10);
    wr(ADDR_MATCH_B, 8'h30);
    wr(ADDR_MASK, 8'h06);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL_B, 8'h01);
    wait_clk(20);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_FLAG, v);
    chk("match a flag", v, 8'h02);
    chk("match a irq", {5'h0, irq_req_r}, 8'h02);
    @(posedge clock) irq_ack <= 3'h2;
    @(posedge clock) irq_ack <= 3'h0;
    wait_clk(2);
    rd(ADDR_FLAG, v);
    chk("ack flag", v, 8'h00);
    chk("ack irq", {5'h0, irq_req_r}, 8'h00);
    $display("test match done");
    // counter write blocks the coinciding match
    wr(ADDR_MATCH_A, 8'h20);
    wr(ADDR_COUNT, 8'h20);
    wr(ADDR_CTRL_B, 8'h01);
    wait_clk(8);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_FLAG, v);
    chk("blocked match", v, 8'h00);
    rd(ADDR_COUNT, v);
    chk("counted up", v, 8'h2a);
    $display("test blocking done");
    // force strobe, kind change, immediate action change
    wr(ADDR_CTRL_A, {ACT_TOGGLE, 6'h00});
    wr(ADDR_CTRL_C, 8'h80);
    wait_clk(2);
    chk("force toggle", {7'h0, wave_out_a}, 8'h01);
    rd(ADDR_FLAG, v);
    chk("force no flag", v, 8'h00);
    rd(ADDR_COUNT, v);
    chk("force no reload", v, 8'h2a);
    wr(ADDR_CTRL_A, {ACT_TOGGLE, 4'h0, WK_CTC[1:0]});
    wait_clk(2);
    chk("kind keeps out", {7'h0, wave_out_a}, 8'h01);
    wr(ADDR_CTRL_A, {ACT_CLEAR, 4'h0, WK_CTC[1:0]});
    wr(ADDR_CTRL_C, 8'h80);
    wait_clk(2);
    chk("force clear", {7'h0, wave_out_a}, 8'h00);
    wr(ADDR_CTRL_A, {ACT_CLEAR, ACT_SET, 2'h0, WK_CTC[1:0]});
    wr(ADDR_CTRL_C, 8'h40);
    wait_clk(2);
    chk("force b set", {6'h00, wave_out_a, wave_out_b}, 8'h01);
    $display("test force done");
    // clear_on_match keeps count at or below match a
    wr(ADDR_CTRL_A, {6'h00, WK_CTC[1:0]});
    wr(ADDR_MATCH_A, 8'h05);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL_B, 8'h01);
    repeat (12) begin
      rd(ADDR_COUNT, v);
      chk("ctc top", 8'(v <= 8'h05), 8'h01);
    end
    wr(ADDR_CTRL_B, 8'h00);
    $display("test clear_on_match done");
    // fast pwm: compare b buffered until top
    wr(ADDR_CTRL_A, 8'h03);
    wr(ADDR_COUNT, 8'h05);
    wr(ADDR_MATCH_B, 8'h08);
    rd(ADDR_MATCH_B, v);
    chk("buffer read", v, 8'h08);
    wr(ADDR_FLAG, 8'h07);
    wr(ADDR_CTRL_B, 8'h01);
    wait_clk(10);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_FLAG, v);
    chk("buffer held", v & 8'h04, 8'h00);
    wr(ADDR_CTRL_B, 8'h01);
    wait_clk(300);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_FLAG, v);
    chk("buffer loaded", v & 8'h04, 8'h04);
    $display("test buffering done");
    // phase pwm turns at top and again at bottom
    wr(ADDR_CTRL_A, 8'h01);
    wr(ADDR_FLAG, 8'h07);
    wr(ADDR_COUNT, 8'hfd);
    wr(ADDR_CTRL_B, 8'h01);
    wait_clk(260);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_COUNT, v);
    chk("phase count", v, 8'h05);
    rd(ADDR_FLAG, v);
    chk("phase overflow", v & 8'h01, 8'h01);
    wr(ADDR_CTRL_A, 8'h00);
    $display("test phase done");
    // prescaled sources, shared divider may shift by one tick
    for (int s = 2; s < 6; s++) begin
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_CTRL_B, 8'(s));
      // divider per source code: 8, 64, 256, 1024
      wait_clk(10 * (s == 2 ? 8 : s == 3 ? 64 : s == 4 ? 256 : 1024));
      wr(ADDR_CTRL_B, 8'h00);
      rd(ADDR_COUNT, v);
      chk("prescale", 8'(v >= 8'h09 && v <= 8'h0b), 8'h01);
    end
    $display("test prescaler done");
    // external pin, both edges
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL_B, {5'h00, SRC_EXT_RISE});
    pin_pulses(2);
    rd(ADDR_COUNT, v);
    chk("pin rise", v, 8'h02);
    wr(ADDR_CTRL_B, {5'h00, SRC_EXT_FALL});
    pin_pulses(2);
    rd(ADDR_COUNT, v);
    chk("pin fall", v, 8'h04);
    $display("test pin done");
    // mid-run reset returns counter and outputs to zero
    @(posedge clock) arst_n <= 1'b0;
    wait_clk(5);
    @(posedge clock) arst_n <= 1'b1;
    rd(ADDR_COUNT, v);
    chk("rerun count", v, RESET_BYTE);
    chk("rerun outs", {3'h0, irq_req_r, wave_out_a, wave_out_b}, 8'h00);
    $display("test rerun done");
    close_out();
  end
endmodule
